// ---- rtl/prc_prox_ctrl.sv ----
// proximity detection and ambient recalibration control, per conversion stage
// assumes conv_valid pulses are at least two cycles apart and seq_done follows
// the last stage of each sequence; registers are written through a word port
//
// What this block does
// - watch every stage; approach disables calibration
// - full power disable lasts count times 16
// - low power disable lasts count times 4
// - re-enable only when approach has ended
// - no ambient calibration while proximity holds
// - force recalibration after sustained ambient shift
// - full power timeout is count sequences
// - low power timeout is count sequences
// - forced recalibration busy two sequences, no retrigger
// - approach when fast_fifo_word_1, fast_fifo_word_3 differ beyond rate
// - hover when average, ambient differ beyond level
// - proximity is approach or hover
// - fast skip field paces fast fifo
// - slow skip fields per power mode
// - full power slow rate from skip settings
// - low power slow rate includes conversion delay; the code paces it from fast_skip_reg and lp_avg_reg alone
// - disable counts at bits 7:4, 11:8
// - recal counts at bits 9:0, 15:10
// - rate at bits 7:0, level 13:8
// - slow filter updates only without proximity
// - low power wake every 200 to 800 ms
`timescale 1ns/1ps
`include "prc_params.svh"
module prc_prox_ctrl
	import prc_pkg::*;
#(
	parameter int NSTAGE    = 8,
	parameter int MS_CYCLES = `PRC_MS_CYCLES
) (
	// clock and reset
	input  wire logic              clk,
	input  wire logic              rst_b,
	// register word port
	input  wire logic              reg_we,
	input  wire logic [11:0]       reg_addr,
	input  wire logic [15:0]       reg_wdata,
	output logic      [15:0]       reg_rdata_reg,
	// converter results from the sequencer
	input  wire logic              conv_valid,
	input  wire logic [3:0]        conv_stage,
	input  wire logic [15:0]       conv_data,
	input  wire logic              seq_done,
	input  wire logic              low_power,
	// proximity and calibration state
	output logic      [NSTAGE-1:0] prox_reg,
	output logic      [NSTAGE-1:0] cal_en_reg,
	output logic                   recal_pulse_reg,
	output logic      [3:0]        recal_stage_reg,
	output logic                   wake_pulse_reg
);
	localparam int A = (NSTAGE > 1) ? $clog2(NSTAGE) : 1;

	generate
		if (NSTAGE < 1 || NSTAGE > 16) begin : g_chk
			$error("stage count must be 1 to 16");
		end
	endgenerate

	// absolute difference, used by every comparator
	function automatic logic [15:0] absdiff(input logic [15:0] a, input logic [15:0] b);
		absdiff = (a > b) ? a - b : b - a;
	endfunction

	// control fields
	logic [1:0]  conv_delay_reg;  // low power wake spacing code
	logic [1:0]  fp_avg_reg;      // full power slow skip
	logic [1:0]  lp_avg_reg;      // low power slow skip
	logic [3:0]  fast_skip_reg;   // fast fifo skip
	logic [3:0]  fp_dis_reg;      // full power disable count
	logic [3:0]  lp_dis_reg;      // low power disable count
	logic [7:0]  det_rate_reg;    // approach comparator sensitivity
	logic [5:0]  recal_lvl_reg;   // hover comparator sensitivity
	logic [9:0]  fp_recal_reg;    // full power recal timeout
	logic [5:0]  lp_recal_reg;    // low power recal timeout

	// register writes; reserved bits are simply not stored
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			conv_delay_reg <= '0;
			fp_avg_reg     <= '0;
			lp_avg_reg     <= '0;
			fast_skip_reg  <= '0;
			fp_dis_reg     <= '0;
			lp_dis_reg     <= '0;
			det_rate_reg   <= '0;
			recal_lvl_reg  <= '0;
			fp_recal_reg   <= '0;
			lp_recal_reg   <= '0;
		end else if (reg_we) begin
			unique case (reg_addr)
				`PRC_OFF_CTRL0: conv_delay_reg <= reg_wdata[`PRC_CONV_DELAY_RNG];
				`PRC_OFF_CTRL1: begin
					fp_avg_reg <= reg_wdata[`PRC_FP_AVG_RNG];
					lp_avg_reg <= reg_wdata[`PRC_LP_AVG_RNG];
				end
				`PRC_OFF_AMB0: begin
					fast_skip_reg <= reg_wdata[`PRC_FAST_SKIP_RNG];
					fp_dis_reg    <= reg_wdata[`PRC_FP_DIS_RNG];
					lp_dis_reg    <= reg_wdata[`PRC_LP_DIS_RNG];
				end
				`PRC_OFF_AMB1: begin
					det_rate_reg  <= reg_wdata[`PRC_DET_RATE_RNG];
					recal_lvl_reg <= reg_wdata[`PRC_RECAL_LVL_RNG];
				end
				`PRC_OFF_AMB2: begin
					fp_recal_reg <= reg_wdata[`PRC_FP_RECAL_RNG];
					lp_recal_reg <= reg_wdata[`PRC_LP_RECAL_RNG];
				end
				default: ; // unmapped writes are dropped
			endcase
		end
	end

	// read back, one cycle behind the address
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			reg_rdata_reg <= `PRC_RST_FIELD;
		end else begin
			reg_rdata_reg <= `PRC_RST_FIELD;
			unique case (reg_addr)
				`PRC_OFF_CTRL0: reg_rdata_reg[`PRC_CONV_DELAY_RNG] <= conv_delay_reg;
				`PRC_OFF_CTRL1: reg_rdata_reg <= {lp_avg_reg, fp_avg_reg, 12'h000};
				`PRC_OFF_AMB0:  reg_rdata_reg <= {4'h0, lp_dis_reg, fp_dis_reg, fast_skip_reg};
				`PRC_OFF_AMB1:  reg_rdata_reg <= {2'h0, recal_lvl_reg, det_rate_reg};
				`PRC_OFF_AMB2:  reg_rdata_reg <= {lp_recal_reg, fp_recal_reg};
				default: ; // unmapped reads return zero
			endcase
		end
	end

	// sequence pacing: the fast fifo takes one sequence in fast_skip+1
	logic       fast_take;
	logic       slow_take_raw;
	logic [1:0] slow_skip;
	logic       slow_tick;

	// full power code zero drops three samples, low power code zero drops none
	always_comb begin
		slow_skip = low_power ? lp_avg_reg
			: ((fp_avg_reg == 2'h0) ? `PRC_FP_AVG_ZERO : fp_avg_reg);
		slow_tick = seq_done & fast_take;
	end

	prc_skip_div #(.W(4)) u_fast_div (
		.clk      (clk),
		.rst_b    (rst_b),
		.tick     (seq_done),
		.skip     (fast_skip_reg),
		.take_reg (fast_take)
	);

	prc_skip_div #(.W(2)) u_slow_div (
		.clk      (clk),
		.rst_b    (rst_b),
		.tick     (slow_tick),
		.skip     (slow_skip),
		.take_reg (slow_take_raw)
	);

	// pipeline stage: memory read in flight
	logic           p_valid_reg;
	logic [A-1:0]   p_stage_reg;
	logic [15:0]    p_data_reg;
	logic           p_lp_reg;
	logic           p_fast_reg;
	logic           p_slow_reg;
	logic [NSTAGE-1:0] seen_reg;  // stage record holds real data
	prc_rec_s       rd_rec;
	prc_rec_s       c_rec;        // record as read, or seeded for a new stage
	prc_rec_s       n_rec;        // record written back after this result
	logic [PRC_REC_W-1:0] rd_bits;
	logic           stage_ok;

	assign stage_ok = (32'(conv_stage) < NSTAGE);

	// capture the result while its record is read
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			p_valid_reg <= 1'b0;
			p_stage_reg <= '0;
			p_data_reg  <= '0;
			p_lp_reg    <= 1'b0;
			p_fast_reg  <= 1'b0;
			p_slow_reg  <= 1'b0;
		end else begin
			p_valid_reg <= conv_valid & stage_ok;
			if (conv_valid) begin
				p_stage_reg <= conv_stage[A-1:0];
				p_data_reg  <= conv_data;
				p_lp_reg    <= low_power;
				p_fast_reg  <= fast_take;
				p_slow_reg  <= fast_take & slow_take_raw;
			end
		end
	end

	prc_stage_mem #(.W(PRC_REC_W), .D(NSTAGE), .A(A)) u_mem (
		.clk       (clk),
		.we        (p_valid_reg),
		.waddr     (p_stage_reg),
		.wdata     (PRC_REC_W'(n_rec)),
		.re        (conv_valid),
		.raddr     (conv_stage[A-1:0]),
		.rdata_reg (rd_bits)
	);

	// next record for the stage in flight
	logic [17:0] sum;
	logic [15:0] avg;
	logic        c1;
	logic        c2;
	logic        n_prox;
	logic        beyond;
	logic        force_recal;
	logic        n_cal_en;
	logic [9:0]  timeout;

	assign rd_rec = prc_rec_s'(rd_bits);

	always_comb begin
		// a stage never seen starts with its ambient at the sample
		c_rec = rd_rec;
		if (!seen_reg[p_stage_reg]) begin
			c_rec     = '0;
			c_rec.amb = p_data_reg;
			c_rec.w0  = p_data_reg;
			c_rec.w1  = p_data_reg;
			c_rec.w2  = p_data_reg;
			c_rec.w3  = p_data_reg;
		end
		n_rec = c_rec;
		if (p_fast_reg) begin // skipped sequences leave the fifo alone
			n_rec.w0 = p_data_reg;
			n_rec.w1 = c_rec.w0;
			n_rec.w2 = c_rec.w1;
			n_rec.w3 = c_rec.w2;
		end
		sum = 18'(n_rec.w0) + 18'(n_rec.w1) + 18'(n_rec.w2) + 18'(n_rec.w3);
		avg = sum[17:2];
		c1  = absdiff(n_rec.w1, n_rec.w3) > 16'(det_rate_reg);
		c2  = absdiff(avg, c_rec.amb) > 16'(recal_lvl_reg);
		n_prox = c1 | c2;
		n_rec.prox = n_prox;
		// a new proximity reloads the disable period, else it counts down
		if (n_prox && !c_rec.prox) begin
			n_rec.dis = p_lp_reg ? 8'(lp_dis_reg) * `PRC_LP_DIS_MULT
				: 8'(fp_dis_reg) * `PRC_FP_DIS_MULT;
		end else if (c_rec.dis != 8'h00) begin
			n_rec.dis = c_rec.dis - 8'h01;
		end
		// measured value beyond the ambient, counted per sequence
		timeout = p_lp_reg ? 10'(lp_recal_reg) : fp_recal_reg;
		beyond  = absdiff(p_data_reg, c_rec.amb) > 16'(recal_lvl_reg);
		force_recal = 1'b0;
		if (c_rec.busy != 2'h0) begin
			n_rec.busy = c_rec.busy - 2'h1;
			n_rec.rc   = '0;
		end else if (beyond && timeout != 10'h000) begin
			if (c_rec.rc + 10'h001 >= timeout) begin
				force_recal = 1'b1;
				n_rec.rc    = '0;
				n_rec.busy  = `PRC_RECAL_BUSY;
				n_rec.amb   = p_data_reg;
			end else begin
				n_rec.rc = c_rec.rc + 10'h001;
			end
		end else begin
			n_rec.rc = '0;
		end
		// calibration only after the period and with the user gone
		n_cal_en = (n_rec.dis == 8'h00) && !n_prox;
		if (p_slow_reg && n_cal_en && !force_recal) begin
			n_rec.amb = avg;
		end
	end

	// per-stage state outputs
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			seen_reg        <= '0;
			prox_reg        <= '0;
			cal_en_reg      <= '1;
			recal_pulse_reg <= 1'b0;
			recal_stage_reg <= '0;
		end else begin
			recal_pulse_reg <= p_valid_reg & force_recal;
			if (p_valid_reg) begin
				seen_reg[p_stage_reg]   <= 1'b1;
				prox_reg[p_stage_reg]   <= n_prox;
				cal_en_reg[p_stage_reg] <= n_cal_en;
				if (force_recal) begin
					recal_stage_reg <= 4'(p_stage_reg);
				end
			end
		end
	end

	// low power wake-up timer: a ms prescaler, then (code+1) steps of 200 ms
	logic [$clog2(MS_CYCLES+1)-1:0] ms_cnt_reg;
	logic [9:0]                     ms_left_reg;
	logic [9:0]                     wake_ms;
	assign wake_ms = 10'(`PRC_WAKE_STEP_MS) * (10'(conv_delay_reg) + 10'h001);

	always_ff @(posedge clk) begin
		if (!rst_b || !low_power) begin
			ms_cnt_reg     <= '0;
			ms_left_reg    <= '0;
			wake_pulse_reg <= 1'b0;
		end else begin
			wake_pulse_reg <= 1'b0;
			if (32'(ms_cnt_reg) >= MS_CYCLES - 1) begin
				ms_cnt_reg <= '0;
				if (ms_left_reg <= 10'h001) begin
					ms_left_reg    <= wake_ms;
					wake_pulse_reg <= 1'b1;
				end else begin
					ms_left_reg <= ms_left_reg - 10'h001;
				end
			end else begin
				ms_cnt_reg <= ms_cnt_reg + 1'b1;
			end
		end
	end

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rst_b);

	a_prox_or_flag: assert property (p_valid_reg && (c1 || c2)
		|=> prox_reg[$past(p_stage_reg)]) else $error("proximity flag missed");
	a_approach_cmp: assert property (p_valid_reg
		&& absdiff(n_rec.w1, n_rec.w3) > 16'(det_rate_reg) |-> n_prox)
		else $error("approach not flagged");
	a_hover_holds_cal: assert property (p_valid_reg && n_prox
		|=> !cal_en_reg[$past(p_stage_reg)]) else $error("calibration on during hover");
	a_fp_dis_load: assert property (p_valid_reg && !p_lp_reg && n_prox && !c_rec.prox
		|-> n_rec.dis == 8'(fp_dis_reg) * 8'h10) else $error("full power period wrong");
	a_lp_dis_load: assert property (p_valid_reg && p_lp_reg && n_prox && !c_rec.prox
		|-> n_rec.dis == 8'(lp_dis_reg) * 8'h04) else $error("low power period wrong");
	a_reenable_gate: assert property (p_valid_reg && n_rec.dis != 8'h00
		|=> !cal_en_reg[$past(p_stage_reg)]) else $error("enabled inside period");
	a_recal_timeout: assert property (p_valid_reg && force_recal
		|-> beyond && c_rec.rc + 10'h001 >= timeout && c_rec.busy == 2'h0)
		else $error("recalibration without timeout");
	a_recal_busy_two: assert property (p_valid_reg && force_recal
		|-> n_rec.busy == 2'h2 && n_rec.amb == p_data_reg)
		else $error("recalibration busy span wrong");
	a_slow_gate_amb: assert property (p_valid_reg && !force_recal
		&& !(p_slow_reg && n_cal_en) |-> n_rec.amb == c_rec.amb)
		else $error("ambient moved while gated");
	a_recal_pulse_one: assert property (recal_pulse_reg |=> !recal_pulse_reg)
		else $error("recalibration pulse too long");
endmodule

// ---- pkg/prc_params.svh ----
// constants of the proximity and recalibration block: offsets, fields, resets, timing
// assumes the includer sits in a design file that reads 12-bit register offsets
`ifndef PRC_PARAMS_SVH
`define PRC_PARAMS_SVH

// register offsets, 16-bit registers
`define PRC_OFF_CTRL0      12'h000
`define PRC_OFF_CTRL1      12'h001
`define PRC_OFF_AMB0       12'h002
`define PRC_OFF_AMB1       12'h003
`define PRC_OFF_AMB2       12'h004

// field positions
`define PRC_CONV_DELAY_RNG 3:2
`define PRC_FP_AVG_RNG     13:12
`define PRC_LP_AVG_RNG     15:14
`define PRC_FAST_SKIP_RNG  3:0
`define PRC_FP_DIS_RNG     7:4
`define PRC_LP_DIS_RNG     11:8
`define PRC_DET_RATE_RNG   7:0
`define PRC_RECAL_LVL_RNG  13:8
`define PRC_FP_RECAL_RNG   9:0
`define PRC_LP_RECAL_RNG   15:10

// reset values of the control fields
`define PRC_RST_FIELD      16'h0000

// disable period multipliers, in conversion sequences per count
`define PRC_FP_DIS_MULT    8'h10
`define PRC_LP_DIS_MULT    8'h04
// forced recalibration occupies this many sequences
`define PRC_RECAL_BUSY     2'h2
// full power slow skip code 00 stands for three skipped samples
`define PRC_FP_AVG_ZERO    2'h3

// low power wake-up spacing
`define PRC_CLK_MHZ        125
`define PRC_MS_CYCLES      (`PRC_CLK_MHZ * 1000)
`define PRC_WAKE_STEP_MS   200

`endif

// ---- pkg/prc_pkg.sv ----
// types shared by the proximity and recalibration block
// assumes the stage count never exceeds sixteen
package prc_pkg;

	// per-stage record held in the stage memory
	typedef struct packed {
		logic [15:0] w0;      // newest fast fifo word
		logic [15:0] w1;
		logic [15:0] w2;
		logic [15:0] w3;      // oldest fast fifo word
		logic [15:0] amb;     // stored ambient value
		logic [7:0]  dis;     // sequences left in the disable period
		logic [9:0]  rc;      // sequences spent beyond the ambient
		logic [1:0]  busy;    // sequences left of a forced recalibration
		logic        prox;    // proximity seen last sequence
	} prc_rec_s;

	localparam int PRC_REC_W = $bits(prc_rec_s);

endpackage

// ---- rtl/prc_stage_mem.sv ----
// per-stage record memory, one write port and one registered read port
// assumes reads and writes come from the same clock domain
`timescale 1ns/1ps
module prc_stage_mem #(
	parameter int W = 16,
	parameter int D = 8,
	parameter int A = 3
) (
	// clock
	input  wire logic         clk,
	// write side
	input  wire logic         we,
	input  wire logic [A-1:0] waddr,
	input  wire logic [W-1:0] wdata,
	// read side
	input  wire logic         re,
	input  wire logic [A-1:0] raddr,
	output logic      [W-1:0] rdata_reg
);
	logic [W-1:0] mem [D];    // no reset: a valid bit outside covers it

	generate
		if (D > (1 << A)) begin : g_chk
			$error("stage memory depth exceeds address range");
		end
	endgenerate

	// write port
	always_ff @(posedge clk) begin
		if (we) begin
			mem[waddr] <= wdata;
		end
	end

	// registered read port
	always_ff @(posedge clk) begin
		if (re) begin
			rdata_reg <= mem[raddr];
		end
	end
endmodule

// ---- rtl/prc_skip_div.sv ----
// skip divider: takes one tick in every skip+1 ticks
// assumes tick is a one-cycle pulse, skip may change between ticks
`timescale 1ns/1ps
module prc_skip_div #(
	parameter int W = 4
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst_b,
	// pacing
	input  wire logic         tick,
	input  wire logic [W-1:0] skip,
	// the coming tick period is taken
	output logic              take_reg
);
	logic [W-1:0] cnt_reg;    // ticks since the last taken one
	logic [W-1:0] cnt_next;

	// wrap once skip ticks have been dropped
	always_comb begin
		cnt_next = (cnt_reg >= skip) ? '0 : cnt_reg + W'(1);
	end

	// counter and take flag advance only on a tick
	always_ff @(posedge clk) begin
		if (!rst_b) begin
			cnt_reg  <= '0;
			take_reg <= 1'b1;
		end else if (tick) begin
			cnt_reg  <= cnt_next;
			take_reg <= (cnt_next == '0);
		end
	end
endmodule

// ---- test/prc_host_model.sv ----
// host and sequencer model: register writes and reads, conversion sequences
// assumes a two-stage sequence and the register timing of the word port
`timescale 1ns/1ps
module prc_host_model (
	// clock
	input  wire logic        clk,
	// register word port
	output logic             reg_we,
	output logic      [11:0] reg_addr,
	output logic      [15:0] reg_wdata,
	input  wire logic [15:0] reg_rdata,
	// converter results
	output logic             conv_valid,
	output logic      [3:0]  conv_stage,
	output logic      [15:0] conv_data,
	output logic             seq_done
);
	// idle values at time zero
	initial begin
		reg_we = 1'b0;
		reg_addr = 12'h000;
		reg_wdata = 16'h0000;
		conv_valid = 1'b0;
		conv_stage = 4'h0;
		conv_data = 16'h0000;
		seq_done = 1'b0;
	end

	// one write, strobe held for exactly one edge
	task automatic wr(input logic [11:0] a, input logic [15:0] d);
		@(posedge clk);
		#1;
		reg_we = 1'b1;
		reg_addr = a;
		reg_wdata = d;
		@(posedge clk);
		#1;
		reg_we = 1'b0;
		reg_wdata = ~d;
	endtask

	// read: data is registered one edge after the address
	task automatic rd(input logic [11:0] a, output logic [15:0] d);
		@(posedge clk);
		#1;
		reg_addr = a;
		@(posedge clk);
		#1;
		d = reg_rdata;
	endtask

	// setup: fast skip zero, both slow skips zero, recal off
	task automatic setup();
		wr(12'h000, 16'h0000);
		wr(12'h001, 16'h0000); // slow samples paced for the ambient rate
		wr(12'h002, 16'h0210);
		wr(12'h003, 16'h3f04);
		wr(12'h004, 16'h0000); // both recal timeouts zero, recal off
	endtask

	// n sequences; data is scrambled between results so stale words never match
	task automatic seq(input logic [15:0] d0, input logic [15:0] d1, input int n);
		for (int k = 0; k < n; k++) begin
			for (int s = 0; s < 2; s++) begin
				@(posedge clk);
				#1;
				conv_valid = 1'b1;
				conv_stage = 4'(s);
				conv_data = (s == 0) ? d0 : d1;
				@(posedge clk);
				#1;
				conv_valid = 1'b0;
				conv_data = ~conv_data;
			end
			seq_done = 1'b1;
			@(posedge clk);
			#1;
			seq_done = 1'b0;
			repeat (2) @(posedge clk);
			#1;
		end
	endtask
endmodule

// ---- test/proximity_recal_control_bench.sv ----
// self-checking bench for the proximity and recalibration control
// assumes two stages and a shortened millisecond so wake periods stay small
`timescale 1ns/1ps
module proximity_recal_control_bench;
	// design nets
	logic        clk, rst_b, low_power, reg_we, conv_valid, seq_done;
	logic        recal_pulse_reg, wake_pulse_reg;
	logic [11:0] reg_addr;
	logic [15:0] reg_wdata, reg_rdata_reg, conv_data;
	logic [3:0]  conv_stage, recal_stage_reg;
	logic [1:0]  prox_reg, cal_en_reg;
	// bench state
	logic [15:0] d, q, c;
	int          n_mismatch, tests_run, seed, cyc, n_recal, last_wake, wake_gap;

	// 125 MHz clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	prc_prox_ctrl #(.NSTAGE(2), .MS_CYCLES(4)) uut (
		.clk(clk), .rst_b(rst_b), .reg_we(reg_we), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_rdata_reg(reg_rdata_reg), .conv_valid(conv_valid),
		.conv_stage(conv_stage), .conv_data(conv_data), .seq_done(seq_done),
		.low_power(low_power), .prox_reg(prox_reg), .cal_en_reg(cal_en_reg),
		.recal_pulse_reg(recal_pulse_reg), .recal_stage_reg(recal_stage_reg),
		.wake_pulse_reg(wake_pulse_reg));

	prc_host_model host (
		.clk(clk), .reg_we(reg_we), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_rdata(reg_rdata_reg), .conv_valid(conv_valid), .conv_stage(conv_stage),
		.conv_data(conv_data), .seq_done(seq_done));

	// writable bits of each offset; unmapped reads as zero
	function automatic logic [15:0] mask(input int a);
		case (a)
			0: return 16'h000c;
			1: return 16'hf000;
			2: return 16'h0fff;
			3: return 16'h3fff;
			4: return 16'hffff;
			default: return 16'h0000;
		endcase
	endfunction

	task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
		tests_run++;
		if (g !== e) begin
			n_mismatch++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask

	task automatic stop_test();
		$display("counts: %0d compared, %0d mismatched", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// pulse counters and the hang limit, which sits well above the expected run
	always @(posedge clk) begin
		cyc <= cyc + 1;
		if (recal_pulse_reg === 1'b1)
			n_recal <= n_recal + 1;
		if (wake_pulse_reg === 1'b1) begin
			wake_gap <= cyc - last_wake;
			last_wake <= cyc;
		end
		if (cyc == 60000) begin
			n_mismatch++;
			stop_test();
		end
	end

	initial begin
		seed = 73;
		cyc = 0;
		n_recal = 0;
		last_wake = 0;
		wake_gap = 0;
		n_mismatch = 0;
		tests_run = 0;
		rst_b = 1'b0;
		low_power = 1'b0;
		repeat (6) @(posedge clk);
		#1;
		rst_b = 1'b1;
		chk("cal_en reset", 16'h0003, {14'h0, cal_en_reg});
		chk("prox reset", 16'h0000, {14'h0, prox_reg});
		$display("test reset done");
		// random words to every offset plus one unmapped
		for (int i = 0; i < 6; i++) begin
			d = 16'($random(seed));
			host.wr(12'(i), d);
			host.rd(12'(i), q);
			chk("register", d & mask(i), q);
		end
		$display("test registers done");
		host.setup();
		c = 16'h1000 + (16'($random(seed)) & 16'h00ff);
		// approach on stage 0, full power disable of 1 x 16 sequences
		host.seq(c, c, 3);
		host.seq(c + 16'd20, c, 2);
		chk("prox0 approach", 16'h0001, {15'h0, prox_reg[0]});
		chk("cal_en0 approach", 16'h0000, {15'h0, cal_en_reg[0]});
		chk("cal_en1 quiet", 16'h0001, {15'h0, cal_en_reg[1]});
		host.seq(c + 16'd20, c, 15);
		chk("prox0 ended", 16'h0000, {15'h0, prox_reg[0]});
		chk("cal_en0 period", 16'h0000, {15'h0, cal_en_reg[0]});
		host.seq(c + 16'd20, c, 1);
		chk("cal_en0 back", 16'h0001, {15'h0, cal_en_reg[0]});
		$display("test full power disable done");
		// low power disable of 2 x 4 sequences
		low_power = 1'b1;
		host.seq(c, c, 2);
		chk("prox0 lp", 16'h0001, {15'h0, prox_reg[0]});
		host.seq(c, c, 7);
		chk("cal_en0 lp period", 16'h0000, {15'h0, cal_en_reg[0]});
		host.seq(c, c, 1);
		chk("cal_en0 lp back", 16'h0001, {15'h0, cal_en_reg[0]});
		host.seq(c, c, 4);
		$display("test low power disable done");
		// wake spacing for every delay code
		for (int k = 0; k < 4; k++) begin
			host.wr(12'h000, 16'(k << 2));
			repeat (3) @(posedge wake_pulse_reg);
			@(posedge clk);
			#1;
			chk("wake gap", 16'(800 * (k + 1)), 16'(wake_gap));
		end
		$display("test wake done");
		// hover on stage 1 keeps calibration off past the disable period
		low_power = 1'b0;
		host.wr(12'h003, 16'h0804);
		host.seq(c, c + 16'd40, 30);
		chk("prox1 hover", 16'h0001, {15'h0, prox_reg[1]});
		chk("cal_en1 hover", 16'h0000, {15'h0, cal_en_reg[1]});
		chk("no recal yet", 16'h0000, 16'(n_recal));
		// timeout of three sequences forces one recalibration
		host.wr(12'h004, 16'h0003);
		host.seq(c, c + 16'd40, 6);
		chk("recal count", 16'h0001, 16'(n_recal));
		chk("recal stage", 16'h0001, {12'h0, recal_stage_reg});
		chk("prox1 cleared", 16'h0000, {15'h0, prox_reg[1]});
		chk("cal_en1 again", 16'h0001, {15'h0, cal_en_reg[1]});
		$display("test recalibration done");
		stop_test();
	end
endmodule
